// ===== hdl/rcs_startup.sv
`timescale 1ns/1ps
`include "rcs_regs.svh"
module rcs_startup #(
    parameter int DLY_SHORT_CYC = `RCS_DLY_SHORT_CYC,
    parameter int DLY_LONG_CYC  = `RCS_DLY_LONG_CYC
) (
    input  wire logic                i_mclk,    // System clock, 40 MHz.
    input  wire logic                i_nrst,    // Synchronous reset, active low.
    input  wire rcs_pkg::rcs_fuse_t  i_fuse,    // Configuration fuses.
    input  wire logic                i_osc_ck,  // Oscillator tick pulse, from a pin.
    input  wire logic                i_wake,    // Wake request pulse, from a pin.
    output logic                     o_clk_en,  // Core clock released.
    output rcs_pkg::rcs_status_t     o_status   // Decoded source and range.
);
    import rcs_pkg::*;

    // Two-stage synchronisers for the pin inputs.
    logic [1:0] s1_reg, s1_next, s2_reg, s2_next;
    logic       tick_prev_reg, tick_prev_next;
    logic       wake_prev_reg, wake_prev_next;
    always_comb begin
        s1_next        = {i_osc_ck, i_wake};
        s2_next        = s1_reg;
        tick_prev_next = s2_reg[1];
        wake_prev_next = s2_reg[0];
    end
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            s1_reg        <= 2'h0;
            s2_reg        <= 2'h0;
            tick_prev_reg <= 1'b0;
            wake_prev_reg <= 1'b0;
        end else begin
            s1_reg        <= s1_next;
            s2_reg        <= s2_next;
            tick_prev_reg <= tick_prev_next;
            wake_prev_reg <= wake_prev_next;
        end
    end
    wire logic tick = s2_reg[1] & ~tick_prev_reg;
    wire logic wake = s2_reg[0] & ~wake_prev_reg;

    // Decode the fuses into source, range and delay settings.
    rcs_status_t dec;
    logic [15:0] osc_cnt_sel;
    logic [31:0] rst_cyc_sel;
    always_comb begin
        dec         = '{src: RCS_SRC_NONE, range: 2'h0, reserved: 1'b0};
        osc_cnt_sel = 16'h0000;
        rst_cyc_sel = 32'h0;
        if (i_fuse.clock_source_select_fuses >= `RCS_SEL_ERC_LO &&
            i_fuse.clock_source_select_fuses <= `RCS_SEL_ERC_HI) begin
            dec.src   = RCS_SRC_ERC; // RL1
            dec.range = 2'(i_fuse.clock_source_select_fuses - `RCS_SEL_ERC_LO); // RL1
            case (i_fuse.startup_time_fuses)
                `RCS_SUT_00: begin
                    osc_cnt_sel = `RCS_ERC_WAKE_CK; // RL2
                    rst_cyc_sel = 32'h0; // RL3
                end
                `RCS_SUT_01: begin
                    osc_cnt_sel = `RCS_ERC_WAKE_CK; // RL2
                    rst_cyc_sel = 32'(DLY_SHORT_CYC); // RL3
                end
                `RCS_SUT_10: begin
                    osc_cnt_sel = `RCS_ERC_WAKE_CK; // RL2
                    rst_cyc_sel = 32'(DLY_LONG_CYC); // RL3
                end
                default: begin
                    osc_cnt_sel = `RCS_ERC_FAST_CK; // RL4
                    rst_cyc_sel = 32'(DLY_SHORT_CYC); // RL4
                end
            endcase
        end else if (i_fuse.clock_source_select_fuses == `RCS_SEL_LFXO) begin
            dec.src = RCS_SRC_LFXO; // RL7
            case (i_fuse.startup_time_fuses)
                `RCS_SUT_00: begin
                    osc_cnt_sel = `RCS_LFXO_1K_CK;
                    rst_cyc_sel = 32'(DLY_SHORT_CYC);
                end
                `RCS_SUT_01: begin
                    osc_cnt_sel = `RCS_LFXO_1K_CK;
                    rst_cyc_sel = 32'(DLY_LONG_CYC);
                end
                `RCS_SUT_10: begin
                    osc_cnt_sel = `RCS_LFXO_32K_CK;
                    rst_cyc_sel = 32'(DLY_LONG_CYC);
                end
                default: dec.reserved = 1'b1; // RL5
            endcase
        end else if (i_fuse.clock_source_select_fuses >= `RCS_SEL_IRC_1M &&
                     i_fuse.clock_source_select_fuses <= `RCS_SEL_IRC_8M) begin
            dec.src   = RCS_SRC_IRC; // RL6
            dec.range = 2'(i_fuse.clock_source_select_fuses - `RCS_SEL_IRC_1M); // RL6
        end
    end

    // Start-up sequencer: oscillator count, then reset delay, then release.
    rcs_state_t  st_reg, st_next;
    logic [15:0] osc_reg, osc_next;
    logic [31:0] dly_reg, dly_next;
    logic        from_rst_reg, from_rst_next;
    logic        en_reg, en_next;
    rcs_status_t stat_reg, stat_next;
    always_comb begin
        st_next       = st_reg;
        osc_next      = osc_reg;
        dly_next      = dly_reg;
        from_rst_next = from_rst_reg;
        en_next       = 1'b0;
        stat_next     = dec;
        case (st_reg)
            RCS_ST_IDLE: begin
                osc_next = osc_cnt_sel;
                dly_next = rst_cyc_sel;
                if (dec.reserved) begin
                    st_next = RCS_ST_IDLE; // RL5
                end else begin
                    st_next = RCS_ST_OSC;
                end
            end
            RCS_ST_OSC: begin
                if (osc_reg == 16'h0000) begin
                    st_next = (from_rst_reg && dly_reg != 32'h0) ? RCS_ST_RST : RCS_ST_RUN; // RL8
                end else if (tick) begin
                    osc_next = osc_reg - 16'h0001; // RL8
                end
            end
            RCS_ST_RST: begin
                if (dly_reg <= 32'h1) begin
                    st_next = RCS_ST_RUN;
                end
                dly_next = dly_reg - 32'h1; // RL8
            end
            RCS_ST_RUN: begin
                en_next = 1'b1;
                if (wake) begin
                    en_next       = 1'b0; // RL8
                    from_rst_next = 1'b0;
                    osc_next      = osc_cnt_sel; // RL2
                    st_next       = RCS_ST_OSC;
                end
            end
            default: st_next = RCS_ST_IDLE;
        endcase
    end
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            st_reg       <= RCS_ST_IDLE;
            osc_reg      <= 16'h0000;
            dly_reg      <= 32'h0;
            from_rst_reg <= 1'b1;
            en_reg       <= 1'b0;
            stat_reg     <= '{src: RCS_SRC_NONE, range: 2'h0, reserved: 1'b0};
        end else begin
            st_reg       <= st_next;
            osc_reg      <= osc_next;
            dly_reg      <= dly_next;
            from_rst_reg <= from_rst_next;
            en_reg       <= en_next;
            stat_reg     <= stat_next;
        end
    end

    // Outputs come straight from flip-flops.
    assign o_clk_en = en_reg;
    assign o_status = stat_reg;
endmodule // rcs_startup

// ===== hdl/rcs_regs.svh
// Functional notes
// RL1: Select codes 0101..1000 pick external RC ranges 0.1-0.9, 0.9-3, 3-8, 8-12 MHz.
// RL2: External RC with start-up codes 00, 01, 10 waits 18 cycles on wake.
// RL3: External RC reset delay: code 00 none, 01 is 4.1 ms, 10 is 65 ms.
// RL4: External RC code 11 gives 6-cycle wake and 4.1 ms reset delay.
// RL5: Low-frequency crystal with start-up code 11 is reserved, no defined delay.
// RL6: Internal RC offers 1, 2, 4 or 8 MHz nominal, chosen by select fuses.
// RL7: Select code 1001 chooses the low-frequency watch crystal.
// RL8: Clock stays gated while oscillator cycles then reset delay are counted.
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH
`define RCS_CLK_HZ        40000000
`define RCS_SEL_ERC_LO    4'h5
`define RCS_SEL_ERC_HI    4'h8
`define RCS_SEL_LFXO      4'h9
`define RCS_SEL_IRC_1M    4'h1
`define RCS_SEL_IRC_2M    4'h2
`define RCS_SEL_IRC_4M    4'h3
`define RCS_SEL_IRC_8M    4'h4
`define RCS_SUT_00        2'h0
`define RCS_SUT_01        2'h1
`define RCS_SUT_10        2'h2
`define RCS_SUT_11        2'h3
`define RCS_ERC_WAKE_CK   16'h0012
`define RCS_ERC_FAST_CK   16'h0006
`define RCS_LFXO_1K_CK    16'h0400
`define RCS_LFXO_32K_CK   16'h8000
`define RCS_DLY_SHORT_US  4100
`define RCS_DLY_LONG_US   65000
`define RCS_DLY_SHORT_CYC (`RCS_DLY_SHORT_US * (`RCS_CLK_HZ / 1000000))
`define RCS_DLY_LONG_CYC  (`RCS_DLY_LONG_US * (`RCS_CLK_HZ / 1000000))
`endif

// ===== hdl/rcs_pkg.sv
package rcs_pkg;
    typedef enum logic [2:0] {
        RCS_SRC_NONE = 3'h0,
        RCS_SRC_ERC  = 3'h1,
        RCS_SRC_LFXO = 3'h2,
        RCS_SRC_IRC  = 3'h3
    } rcs_src_t;
    typedef enum logic [1:0] {
        RCS_ST_IDLE  = 2'h0,
        RCS_ST_OSC   = 2'h1,
        RCS_ST_RST   = 2'h2,
        RCS_ST_RUN   = 2'h3
    } rcs_state_t;
    typedef struct packed {
        logic [3:0] clock_source_select_fuses;
        logic [1:0] startup_time_fuses;
    } rcs_fuse_t;
    typedef struct packed {
        rcs_src_t   src;
        logic [1:0] range;
        logic       reserved;
    } rcs_status_t;
endpackage

// ===== dv/rcs_startup_props.sv
`timescale 1ns/1ps
module rcs_startup_props #(
    parameter int DLY_SHORT_CYC = 20,
    parameter int DLY_LONG_CYC  = 40
) (
    input wire logic                i_mclk,   // System clock.
    input wire logic                i_nrst,   // Synchronous reset, active low.
    input wire rcs_pkg::rcs_fuse_t  i_fuse,   // Configuration fuses.
    input wire logic                i_osc_ck, // Oscillator tick.
    input wire logic                i_wake,   // Wake request.
    input wire logic                o_clk_en, // Core clock release.
    input wire rcs_pkg::rcs_status_t o_status // Decoded source.
);
    import rcs_pkg::*;
    logic [3:0]  sel;
    logic [1:0]  sut;
    logic [15:0] osc_cnt_reg, osc_cnt_next;
    logic        osc_q_reg, osc_q_next;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    // Fuse fields split out for readability.
    assign sel = i_fuse.clock_source_select_fuses;
    assign sut = i_fuse.startup_time_fuses;
    // Counts raw oscillator rises while the core clock is held off.
    always_comb begin
        osc_q_next   = i_osc_ck;
        osc_cnt_next = o_clk_en ? 16'h0000 : osc_cnt_reg + {15'h0000, i_osc_ck & ~osc_q_reg};
    end
    // Registers the counter state.
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            osc_cnt_reg <= 16'h0000;
            osc_q_reg   <= 1'b0;
        end else begin
            osc_cnt_reg <= osc_cnt_next;
            osc_q_reg   <= osc_q_next;
        end
    end
    erc_range_a: assert property ($past(i_nrst, 2) && sel inside {[4'h5:4'h8]} |->
        o_status.src == RCS_SRC_ERC && o_status.range == sel[1:0] - 2'h1) else $error("ext RC decode");
    irc_range_a: assert property ($past(i_nrst, 2) && sel inside {[4'h1:4'h4]} |->
        o_status.src == RCS_SRC_IRC && o_status.range == sel[1:0] - 2'h1) else $error("int RC decode");
    lfxo_src_a: assert property ($past(i_nrst, 2) && sel == 4'h9 |->
        o_status.src == RCS_SRC_LFXO && o_status.reserved == (sut == 2'h3)) else $error("crystal decode");
    reserved_hold_a: assert property (sel == 4'h9 && sut == 2'h3 |-> !o_clk_en)
        else $error("reserved code released clock");
    wake_drop_a: assert property (o_clk_en && $rose(i_wake) |-> ##[1:5] !o_clk_en)
        else $error("wake did not gate clock");
    osc_min_a: assert property ($rose(o_clk_en) && o_status.src == RCS_SRC_ERC |->
        osc_cnt_reg >= (sut == 2'h3 ? 16'h0005 : 16'h0011)) else $error("too few osc cycles");
    osc_max_a: assert property ($rose(o_clk_en) && o_status.src == RCS_SRC_ERC && sut == 2'h0 |->
        osc_cnt_reg <= 16'h0013) else $error("unexpected delay");
    reset_quiet_a: assert property ($rose(i_nrst) |-> !o_clk_en && o_status == 6'h00)
        else $error("outputs not cleared");
endmodule // rcs_startup_props
bind rcs_startup rcs_startup_props #(.DLY_SHORT_CYC(DLY_SHORT_CYC), .DLY_LONG_CYC(DLY_LONG_CYC))
    chk_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_fuse(i_fuse), .i_osc_ck(i_osc_ck),
    .i_wake(i_wake), .o_clk_en(o_clk_en), .o_status(o_status));

// ===== dv/tb_rc_clock_startup_select.sv
`timescale 1ns/1ps
module tb_rc_clock_startup_select;
    import rcs_pkg::*;
    logic        i_mclk, i_nrst, i_osc_ck, i_wake, osc_run, o_clk_en;
    rcs_fuse_t   i_fuse;
    rcs_status_t o_status;
    int          miscompares, compares, ph, t;
    rcs_startup #(.DLY_SHORT_CYC(20), .DLY_LONG_CYC(40)) dut_u (.i_mclk(i_mclk), .i_nrst(i_nrst),
        .i_fuse(i_fuse), .i_osc_ck(i_osc_ck), .i_wake(i_wake), .o_clk_en(o_clk_en),
        .o_status(o_status));
    // Clock generator.
    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end
    // Oscillator pin toggles every four clock cycles while running.
    always @(negedge i_mclk) begin
        ph = osc_run ? (ph + 1) % 4 : 0;
        i_osc_ck = osc_run ? (ph == 0 ? ~i_osc_ck : i_osc_ck) : 1'b0;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic restart(input logic [3:0] sel, input logic [1:0] sut);
        @(negedge i_mclk);
        i_nrst = 1'b0;
        osc_run = 1'b0;
        i_fuse = {sel, sut};
        repeat (5) @(negedge i_mclk);
        i_nrst = 1'b1;
        osc_run = 1'b1;
    endtask
    task automatic wait_en(input logic val);
        t = 0;
        while (o_clk_en !== val && t < 3000) begin
            @(negedge i_mclk);
            t++;
        end
    endtask
    // External RC: reset release timing, status, then a wake cycle.
    task automatic erc_case(input logic [3:0] sel, input logic [1:0] sut);
        int n, d;
        n = (sut == 2'h3) ? 6 : 18;
        d = (sut == 2'h0) ? 0 : (sut == 2'h2) ? 40 : 20;
        restart(sel, sut);
        wait_en(1'b1);
        check("erc release", t >= 8 * n - 8 + d && t <= 8 * n + d + 10, 1);
        check("erc status", o_status, {RCS_SRC_ERC, sel[1:0] - 2'h1, 1'b0});
        i_wake = 1'b1;
        repeat (4) @(negedge i_mclk);
        i_wake = 1'b0;
        check("wake gate", o_clk_en, 0);
        wait_en(1'b1);
        check("wake release", t >= 8 * n - 16 && t <= 8 * n + 10, 1);
        $display("done erc sel %0h sut %0h", sel, sut);
    endtask
    // Internal RC: four ranges, released without counting.
    task automatic irc_case(input logic [3:0] sel);
        restart(sel, 2'h0);
        wait_en(1'b1);
        check("irc release", t <= 20, 1);
        check("irc status", o_status, {RCS_SRC_IRC, sel[1:0] - 2'h1, 1'b0});
        $display("done irc sel %0h", sel);
    endtask
    // Low-frequency crystal: reserved code holds, normal code decodes.
    task automatic lfxo_case();
        restart(4'h9, 2'h3);
        repeat (300) @(negedge i_mclk);
        check("lfxo reserved", o_status, {RCS_SRC_LFXO, 2'h0, 1'b1});
        check("lfxo held", o_clk_en, 0);
        restart(4'h9, 2'h0);
        repeat (10) @(negedge i_mclk);
        check("lfxo status", o_status, {RCS_SRC_LFXO, 2'h0, 1'b0});
        restart(4'ha, 2'h0);
        wait_en(1'b1);
        check("unknown release", t <= 20, 1);
        check("unknown status", o_status, 6'h00);
        $display("done lfxo");
    endtask
    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Watchdog against a hung sequence.
    initial begin
        #(25 * 60000);
        miscompares++;
        complete_run();
    end
    // Main sequence.
    initial begin
        i_nrst = 1'b0;
        i_wake = 1'b0;
        osc_run = 1'b0;
        i_osc_ck = 1'b0;
        ph = 0;
        i_fuse = 6'h00;
        for (int s = 5; s <= 8; s++) begin
            for (int u = 0; u < 4; u++) begin
                erc_case(s[3:0], u[1:0]);
            end
        end
        for (int s = 1; s <= 4; s++) begin
            irc_case(s[3:0]);
        end
        lfxo_case();
        complete_run();
    end
endmodule // tb_rc_clock_startup_select
